// ---- verification/autoneg_partner_page_regs_assertions.sv ----
// Port checker of the page register bank
`timescale 1ns/1ps
module autoneg_page_assertions
  import autoneg_page_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        arst_n,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [15:0] localNextPage,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input page_in_type      basePageIn,
  input page_in_type      nextPageIn,
  input wire logic        parallelFault,
  input wire logic        wordSent,
  input wire logic        sentToggle,
  input pause_mode_type   partnerPause
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  wire rd6 = ack_o && !we_i && adr_i[7:2] == IDX_EXPANSION;
  wire take6 = cyc_i && stb_i && !ack_o && !we_i && adr_i[7:2] == IDX_EXPANSION;
  logic faultPend_ff;
  logic rcvdPend_ff;
  // Expected latched flags from the pins alone; an event in the read cycle survives
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      faultPend_ff <= 1'b0;
      rcvdPend_ff  <= 1'b0;
    end
    else
    begin
      faultPend_ff <= parallelFault || (faultPend_ff && !take6);
      rcvdPend_ff  <= basePageIn.valid || nextPageIn.valid || (rcvdPend_ff && !take6);
    end
  end
  a_ack_single:
    assert property (ack_o |=> !ack_o) else $error("ack held too long");
  a_ack_answer:
    assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("request not acked");
  a_pause_follow:
    assert property (basePageIn.valid |=> partnerPause == $past(basePageIn.word[11:10]))
      else $error("pause field wrong");
  a_toggle_local:
    assert property (wordSent |=> localNextPage[11] == $past(sentToggle))
      else $error("local toggle wrong");
  a_upper_zero:
    assert property (ack_o |-> dat_o[31:16] == 16'h0000) else $error("upper half set");
  a_np_able:
    assert property (rd6 |-> dat_o[2]) else $error("local next page flag low");
  a_rcvd_latch:
    assert property (rd6 |-> dat_o[1] == $past(rcvdPend_ff)) else $error("page flag wrong");
  a_fault_latch:
    assert property (rd6 |-> dat_o[4] == $past(faultPend_ff)) else $error("fault flag wrong");
  a_base_resv:
    assert property (ack_o && adr_i[7:2] == IDX_PARTNER_BASE |-> !dat_o[12])
      else $error("reserved bit set");
endmodule
bind autoneg_partner_page_regs autoneg_page_assertions u_chk (
  .core_clk      (core_clk),
  .arst_n        (arst_n),
  .cyc_i         (cyc_i),
  .stb_i         (stb_i),
  .we_i          (we_i),
  .adr_i         (adr_i),
  .localNextPage (localNextPage),
  .dat_o         (dat_o),
  .ack_o         (ack_o),
  .basePageIn    (basePageIn),
  .nextPageIn    (nextPageIn),
  .parallelFault (parallelFault),
  .wordSent      (wordSent),
  .sentToggle    (sentToggle),
  .partnerPause  (partnerPause)
);

// ---- verification/autoneg_partner_page_regs_tb.sv ----
// Self-checking bench of the page register bank
`timescale 1ns/1ps
`define CHK(a, b) begin nChecks++; if ((a) !== (b)) begin errTotal++; \
  $display("Error at %0t: got %h expected %h", $time, a, b); end end
module autoneg_partner_page_regs_tb
  import autoneg_page_pkg::*;
;
  logic           core_clk, arst_n, cyc_i, stb_i, we_i, wordSent, sentToggle, partnerAnAble;
  logic [7:0]     adr_i;
  logic [3:0]     sel_i;
  logic [31:0]    dat_i, dat_o, rd;
  logic           ack_o, parallelFault;
  logic [15:0]    localNextPage, w;
  page_in_type    basePageIn, nextPageIn;
  pause_mode_type partnerPause;
  int             errTotal, nChecks, cycCnt;
  autoneg_partner_page_regs u_dut (
    .core_clk(core_clk), .arst_n(arst_n), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .basePageIn(basePageIn), .nextPageIn(nextPageIn), .parallelFault(parallelFault),
    .partnerAnAble(partnerAnAble), .wordSent(wordSent), .sentToggle(sentToggle),
    .localNextPage(localNextPage), .partnerPause(partnerPause));
  link_partner_model u_lp (
    .core_clk(core_clk), .basePageIn(basePageIn), .nextPageIn(nextPageIn),
    .parallelFault(parallelFault));
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk)
    if (++cycCnt == 3000)
    begin
      errTotal++;
      wrap_up();
    end
  task automatic wb(input logic wr, input logic [7:0] a, input logic [3:0] s, input logic [15:0] d);
    @(posedge core_clk);
    {cyc_i, stb_i, we_i, adr_i, sel_i} <= {2'b11, wr, a, s};
    dat_i <= {16'h0000, d};
    do @(posedge core_clk); while (ack_o !== 1'b1);
    rd = dat_o;
    {cyc_i, stb_i} <= 2'b00;
  endtask
  task automatic t_reset();
    wb(0, 8'h14, 4'h3, 16'h0000); `CHK(rd, 32'h0000_0001)
    wb(0, 8'h18, 4'h3, 16'h0000); `CHK(rd, 32'h0000_0004)
    wb(0, 8'h1C, 4'h3, 16'h0000); `CHK(rd, 32'h0000_2001)
    wb(0, 8'h20, 4'h3, 16'h0000); `CHK(rd, 32'h0000_0000)
    wb(0, 8'h3C, 4'h3, 16'h0000); `CHK(rd, 32'h0000_0000)
  endtask
  task automatic t_base();
    for (int p = 0; p < 4; p++)
    begin
      w = 16'hF3E1 | {4'h0, p[1:0], 10'h000};
      u_lp.send(0, w);
      // Output only settles after the edge that takes the page
      @(negedge core_clk);
      `CHK(partnerPause, pause_mode_type'(p))
      wb(0, 8'h14, 4'h3, 16'h0000); `CHK(rd[15:0], w & 16'hEFFF)
      wb(0, 8'h18, 4'h3, 16'h0000); `CHK(rd, 32'h0000_000F)
      wb(0, 8'h18, 4'h3, 16'h0000); `CHK(rd, 32'h0000_000D)
    end
    u_lp.fault();
    wb(0, 8'h18, 4'h3, 16'h0000); `CHK(rd, 32'h0000_001D)
    wb(0, 8'h18, 4'h3, 16'h0000); `CHK(rd, 32'h0000_000D)
  endtask
  task automatic t_local();
    wb(1, 8'h1C, 4'h3, 16'hFFFF);
    wb(0, 8'h1C, 4'h3, 16'h0000); `CHK(rd, 32'h0000_B7FF)
    `CHK(localNextPage, 16'hB7FF)
    {wordSent, sentToggle} <= 2'b11;
    @(posedge core_clk);
    wordSent <= 1'b0;
    wb(1, 8'h1C, 4'h1, 16'h0000);
    wb(0, 8'h1C, 4'h3, 16'h0000); `CHK(rd, 32'h0000_BF00)
    wb(1, 8'h14, 4'h3, 16'h0000);
    wb(0, 8'h14, 4'h3, 16'h0000); `CHK(rd, 32'h0000_EFE1)
  endtask
  task automatic t_next();
    u_lp.send(1, 16'hFFFF);
    wb(0, 8'h20, 4'h3, 16'h0000); `CHK(rd, 32'h0000_FFFF)
    u_lp.send(1, 16'h0800);
    wb(0, 8'h20, 4'h3, 16'h0000); `CHK(rd, 32'h0000_0800)
    wb(0, 8'h18, 4'h3, 16'h0000); `CHK(rd, 32'h0000_000F)
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", nChecks, errTotal);
    if (errTotal == 0 && nChecks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    {core_clk, arst_n, cyc_i, stb_i, we_i, wordSent, sentToggle, partnerAnAble} = '0;
    {adr_i, sel_i, dat_i} = '0;
    repeat (5) @(posedge core_clk);
    arst_n <= 1'b1;
    t_reset();
    partnerAnAble <= 1'b1;
    t_base();
    t_local();
    t_next();
    wrap_up();
  end
endmodule

// ---- verification/link_partner_model.sv ----
// Remote link partner handing over received pages
`timescale 1ns/1ps
module link_partner_model
  import autoneg_page_pkg::*;
(
  input  wire logic   core_clk,
  output page_in_type basePageIn,
  output page_in_type nextPageIn,
  output logic        parallelFault
);
  initial
  begin
    basePageIn = '0;
    nextPageIn = '0;
    parallelFault = 1'b0;
  end
  // Word inverted once dropped, so stale data is never mistaken
  task automatic send(input logic nxt, input logic [15:0] w);
    @(posedge core_clk);
    if (nxt)
      nextPageIn <= {1'b1, w};
    else
      basePageIn <= {1'b1, w};
    @(posedge core_clk);
    nextPageIn.valid <= 1'b0;
    basePageIn.valid <= 1'b0;
    if (nxt)
      nextPageIn.word <= ~w;
    else
      basePageIn.word <= ~w;
  endtask
  task automatic fault();
    @(posedge core_clk);
    parallelFault <= 1'b1;
    @(posedge core_clk);
    parallelFault <= 1'b0;
  endtask
endmodule

// ---- verilog/autoneg_page_pkg.sv ----
// Package: offsets, field layouts, reset values and carriers of the page registers
package autoneg_page_pkg;

  // Register indices; byte address is four times the index
  localparam logic [5:0]  IDX_PARTNER_BASE  = 6'h05;
  localparam logic [5:0]  IDX_EXPANSION     = 6'h06;
  localparam logic [5:0]  IDX_LOCAL_NEXT    = 6'h07;
  localparam logic [5:0]  IDX_PARTNER_NEXT  = 6'h08;

  // Shared page word layout
  localparam int          BIT_NEXT_PAGE     = 15;
  localparam int          BIT_ACK           = 14;
  localparam int          BIT_REMOTE_FAULT  = 13;
  localparam int          BIT_MSG_PAGE      = 13;
  localparam int          BIT_ACK2          = 12;
  localparam int          BIT_TOGGLE        = 11;
  localparam int          BIT_PAUSE_LO      = 10;
  localparam int          BIT_PAUSE_HI      = 11;
  localparam int          BIT_FOUR_PAIR     = 9;
  localparam int          BIT_TECH_LO       = 5;

  // Expansion layout
  localparam int          BIT_PAR_FAULT     = 4;
  localparam int          BIT_LP_NP_ABLE    = 3;
  localparam int          BIT_NP_ABLE       = 2;
  localparam int          BIT_PAGE_RCVD     = 1;
  localparam int          BIT_LP_AN_ABLE    = 0;

  // Implemented bits; everything else reads zero, except the local toggle (bit 11) left out of MASK_LOCAL_WR
  localparam logic [15:0] MASK_PARTNER_BASE = 16'hEFFF;
  localparam logic [15:0] MASK_LOCAL_WR     = 16'hB7FF;
  localparam logic [15:0] MASK_PARTNER_NEXT = 16'hFFFF;

  // Reset values
  localparam logic [15:0] RST_PARTNER_BASE  = 16'h0001;
  localparam logic [15:0] RST_LOCAL_NEXT    = 16'h2001;
  localparam logic [15:0] RST_PARTNER_NEXT  = 16'h0000;
  localparam logic        RST_NP_ABLE       = 1'b1;

  typedef enum logic [1:0] {
    PAUSE_NONE = 2'b00,
    PAUSE_SYM  = 2'b01,
    PAUSE_ASYM = 2'b10,
    PAUSE_BOTH = 2'b11
  } pause_mode_type;

  // Word received from the partner, with its strobe
  typedef struct packed {
    logic        valid;
    logic [15:0] word;
  } page_in_type;

  // Whole register state of the block
  typedef struct packed {
    logic [15:0]    partnerBase;
    logic [15:0]    localNext;
    logic [15:0]    partnerNext;
    logic           localToggle;
    logic           parFault;
    logic           pageRcvd;
    logic           lpAnAble;
    pause_mode_type pauseMode;
    logic [31:0]    rdData;
    logic           ack;
  } regs_type;

endpackage

// ---- verilog/autoneg_partner_page_regs.sv ----
// Auto-negotiation partner page and next-page register bank behind a Wishbone slave
//
// Contract
// R01: Partner ability top bit reports partner next-page capability, read-only, reset zero.
// R02: Partner acknowledge bit set once partner link code word received, clear until then.
// R03: Partner remote-fault bit reflects received base page fault, read-only, reset zero.
// R04: Pause field: 00 none, upper only asymmetric, lower only symmetric, both both.
// R05: Technology bits, four-pair down to 10 Mb/s, report advertised abilities, reset zero.
// R06: Five-bit selector field read-only, value 00001 is Ethernet, reset 00001.
// R07: Parallel detection fault flag set on fault, latched until software reads it.
// R08: Expansion bit shows partner next-page capability, read-only, reset zero.
// R09: Expansion bit shows local next-page support, read-only, reset one.
// R10: Page-received flag set on each new partner page, latched until read.
// R11: Lowest expansion bit shows partner auto-negotiation ability, reset zero.
// R12: Local next-page top bit writable, reset zero; one means more pages follow.
// R13: Local message-page bit (reset one) and second acknowledge (reset zero) writable.
// R14: Local toggle read-only, reset zero, reflects toggle of previous transmitted word.
// R15: Local eleven-bit message field writable, 2048 messages, reset one.
// R16: Partner next-page more-pages, message-page, message field read-only, reset zero.
// R17: Partner next-page acknowledge shows partner received the link word.
// R18: Partner second acknowledge shows partner can act on the message.
// R19: Partner toggle reads inverse of previous transmitted word's toggle value.
// R20: Latched flag read returns one, then clears unless condition recurs after read.
// R21: Reserved bits read zero; writes to them have no effect.
`timescale 1ns/1ps

module autoneg_partner_page_regs
  import autoneg_page_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  page_in_type      basePageIn,
  input  page_in_type      nextPageIn,
  input  wire logic        parallelFault,
  input  wire logic        partnerAnAble,
  input  wire logic        wordSent,
  input  wire logic        sentToggle,
  output logic      [15:0] localNextPage,
  output pause_mode_type   partnerPause
);

  regs_type state_ff;
  regs_type nxt_state;

  logic       access;
  logic       wrStrobe;
  logic       rdStrobe;
  logic [5:0] index;
  logic [15:0] wrMask;
  logic [15:0] expansion;

  assign index    = adr_i[7:2];
  // Answer one cycle after the request; ack drops the cycle after it was given
  assign access   = cyc_i && stb_i && !state_ff.ack;
  assign wrStrobe = access && we_i;
  assign rdStrobe = access && !we_i;
  assign wrMask   = {{8{sel_i[1]}}, {8{sel_i[0]}}};

  always_comb
  begin
    expansion                 = 16'h0000; // see R21
    expansion[BIT_PAR_FAULT]  = state_ff.parFault; // see R07
    expansion[BIT_LP_NP_ABLE] = state_ff.partnerBase[BIT_NEXT_PAGE]; // see R08
    expansion[BIT_NP_ABLE]    = RST_NP_ABLE; // see R09
    expansion[BIT_PAGE_RCVD]  = state_ff.pageRcvd; // see R10
    expansion[BIT_LP_AN_ABLE] = state_ff.lpAnAble; // see R11
  end

  always_comb
  begin
    nxt_state     = state_ff;
    nxt_state.ack = access;
    nxt_state.lpAnAble = partnerAnAble; // see R11

    // Base page carries next page, ack, fault, pause, technologies, selector
    if (basePageIn.valid)
    begin
      nxt_state.partnerBase = basePageIn.word & MASK_PARTNER_BASE; // see R01, R02, R03, R05, R06
      nxt_state.pauseMode   = pause_mode_type'(basePageIn.word[BIT_PAUSE_HI:BIT_PAUSE_LO]); // see R04
    end

    // Partner toggle is stored as received; it alternates against our last one
    if (nextPageIn.valid)
    begin
      nxt_state.partnerNext = nextPageIn.word & MASK_PARTNER_NEXT; // see R16, R17, R18, R19
    end

    if (wordSent)
    begin
      nxt_state.localToggle = sentToggle; // see R14
    end

    // Read returns the old value; clearing happens on the same edge
    if (rdStrobe && (index == IDX_EXPANSION))
    begin
      nxt_state.parFault = 1'b0; // see R20
      nxt_state.pageRcvd = 1'b0; // see R20
    end

    // Set after clear so an event in the read cycle is kept
    if (parallelFault)
    begin
      nxt_state.parFault = 1'b1; // see R07, R20
    end
    if (basePageIn.valid || nextPageIn.valid)
    begin
      nxt_state.pageRcvd = 1'b1; // see R10, R20
    end

    // Only local next page is writable; lanes follow sel_i
    if (wrStrobe && (index == IDX_LOCAL_NEXT))
    begin
      nxt_state.localNext = (state_ff.localNext & ~(wrMask & MASK_LOCAL_WR))
                          | (dat_i[15:0] & wrMask & MASK_LOCAL_WR); // see R12, R13, R15, R21
    end

    nxt_state.rdData = 32'h0000_0000;
    if (rdStrobe)
    begin
      unique case (index)
        IDX_PARTNER_BASE:
          nxt_state.rdData = {16'h0000, state_ff.partnerBase};
        IDX_EXPANSION:
          nxt_state.rdData = {16'h0000, expansion};
        IDX_LOCAL_NEXT:
          nxt_state.rdData = {16'h0000, state_ff.localNext[15:12],
                              state_ff.localToggle, state_ff.localNext[10:0]}; // see R14
        IDX_PARTNER_NEXT:
          nxt_state.rdData = {16'h0000, state_ff.partnerNext};
        default:
          nxt_state.rdData = 32'h0000_0000; // see R21
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_ff.partnerBase <= RST_PARTNER_BASE; // see R06
      state_ff.localNext   <= RST_LOCAL_NEXT; // see R12, R13, R15
      state_ff.partnerNext <= RST_PARTNER_NEXT; // see R16
      state_ff.localToggle <= 1'b0;
      state_ff.parFault    <= 1'b0;
      state_ff.pageRcvd    <= 1'b0;
      state_ff.lpAnAble    <= 1'b0;
      state_ff.pauseMode   <= PAUSE_NONE;
      state_ff.rdData      <= 32'h0000_0000;
      state_ff.ack         <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  assign dat_o         = state_ff.rdData;
  assign ack_o         = state_ff.ack;
  assign localNextPage = {state_ff.localNext[15:12], state_ff.localToggle,
                          state_ff.localNext[10:0]};
  assign partnerPause  = state_ff.pauseMode;

endmodule
